// ==== pkg/dpcs_pkg.sv ====
/*
 debug port control/status: bit positions, field widths and the op codes
 passed from the link side to the core. assumes a 32-bit register word.
*/
`default_nettype none
package dpcs_pkg;
	localparam int CSR_W = 32;
	localparam int ACK_W = 3;
	localparam int CNT_W = 12;
	localparam int MASK_W = 4;
	localparam int MODE_W = 2;
	// register word bit positions
	localparam int SYS_ACK_B = 31;
	localparam int SYS_REQ_B = 30;
	localparam int DBG_ACK_B = 29;
	localparam int DBG_REQ_B = 28;
	localparam int RST_ACK_B = 27;
	localparam int RST_REQ_B = 26;
	localparam int CNT_HI_B = 23;
	localparam int CNT_LO_B = 12;
	localparam int MASK_HI_B = 11;
	localparam int MASK_LO_B = 8;
	localparam int WFAULT_B = 7;
	localparam int RDOK_B = 6;
	localparam int STKERR_B = 5;
	localparam int STKCMP_B = 4;
	localparam int MODE_HI_B = 3;
	localparam int MODE_LO_B = 2;
	localparam int ORUN_B = 1;
	localparam int ORUN_EN_B = 0;
	// abort register clear bits
	localparam int AB_ORUN_B = 4;
	localparam int AB_WF_B = 3;
	localparam int AB_ERR_B = 2;
	localparam int AB_CMP_B = 1;
	// where the debugger finds this register
	localparam logic [3:0] SCAN_CSR_ADDR = 4'h4;
	localparam logic [1:0] SWD_CSR_ADDR = 2'h1;
	typedef enum logic [1:0] {DPCS_OP_RD_CSR, DPCS_OP_WR_CSR, DPCS_OP_WR_ABORT} dpcs_op_t;
endpackage
`default_nettype wire

// ==== pkg/dpcs_xfer_if.sv ====
/*
 link-to-core crossing bundle: toggle request with held op and data,
 toggle acknowledge with held read word. carries no clock of its own.
*/
`timescale 1ns/1ps
`default_nettype none
interface dpcs_xfer_if;
	import dpcs_pkg::*;
	logic req_tgl;
	logic fault_tgl;
	dpcs_op_t op;
	logic [CSR_W-1:0] wdata;
	logic ack_tgl;
	logic [CSR_W-1:0] rdata;
	modport link (output req_tgl, output fault_tgl, output op, output wdata,
		input ack_tgl, input rdata);
	modport core (input req_tgl, input fault_tgl, input op, input wdata,
		output ack_tgl, output rdata);
endinterface
`default_nettype wire

// ==== rtl/dpcs_sync.sv ====
/*
 two flip-flop synchroniser, W independent bits.
 assumes each bit is a level or toggle that holds for two clk edges.
*/
`timescale 1ns/1ps
`default_nettype none
module dpcs_sync #(
	parameter int W = 1
) (
	// clock and synchronous reset
	input wire logic clk,
	input wire logic rst_n,
	// async level in, synchronised level out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// first stage feeds only the second stage
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			meta_r <= '0;
			q <= '0;
		end
		else
		begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule
`default_nettype wire

// ==== rtl/dpcs_link.sv ====
/*
 link-side access launcher on link_clk: takes decoded register strobes
 and passes one access at a time to the core over a toggle handshake.
 assumes strobes are single link_clk pulses from the wire decoder.
*/
`timescale 1ns/1ps
`default_nettype none
module dpcs_link (
	// link clock and reset
	input wire logic link_clk,
	input wire logic lnk_rst_n,
	// decoded accesses
	input wire logic lnk_rd_csr,
	input wire logic lnk_wr_csr,
	input wire logic lnk_wr_abort,
	input wire logic [dpcs_pkg::CSR_W-1:0] lnk_wdata,
	input wire logic lnk_wfault,
	// answers
	output logic lnk_busy,
	output logic lnk_rvalid,
	output logic [dpcs_pkg::CSR_W-1:0] lnk_rdata,
	// crossing to the core
	dpcs_xfer_if.link x
);
	import dpcs_pkg::*;
	logic ack_s;
	logic req_r;
	logic fault_r;
	logic rd_pend_r;
	dpcs_op_t op_r;
	logic [CSR_W-1:0] wd_r;
	logic start;
	logic done;

	dpcs_sync #(.W(1)) u_ack_sync (
		.clk(link_clk),
		.rst_n(lnk_rst_n),
		.d(x.ack_tgl),
		.q(ack_s)
	);

	// one access in flight; strobes while busy are dropped, the decoder must wait
	assign start = !lnk_busy && (lnk_rd_csr || lnk_wr_csr || lnk_wr_abort);
	assign done = lnk_busy && (ack_s == req_r);

	// launch: op and data stay frozen until the core toggles back
	always_ff @(posedge link_clk)
	begin
		if (!lnk_rst_n)
		begin
			req_r <= 1'b0;
			lnk_busy <= 1'b0;
			op_r <= DPCS_OP_RD_CSR;
			wd_r <= '0;
			rd_pend_r <= 1'b0;
		end
		else if (start)
		begin
			req_r <= ~req_r;
			lnk_busy <= 1'b1;
			op_r <= lnk_rd_csr ? DPCS_OP_RD_CSR :
				(lnk_wr_csr ? DPCS_OP_WR_CSR : DPCS_OP_WR_ABORT);
			wd_r <= lnk_wdata;
			rd_pend_r <= lnk_rd_csr;
		end
		else if (done)
		begin
			lnk_busy <= 1'b0;
		end
	end

	// read return; core word is stable from the mclk edge its ack toggled
	always_ff @(posedge link_clk)
	begin
		if (!lnk_rst_n)
		begin
			lnk_rvalid <= 1'b0;
			lnk_rdata <= '0;
		end
		else
		begin
			lnk_rvalid <= done && rd_pend_r;
			if (done && rd_pend_r)
				lnk_rdata <= x.rdata;
		end
	end

	// write-data fault from the wire: an event, so it travels as a toggle
	always_ff @(posedge link_clk)
	begin
		if (!lnk_rst_n)
			fault_r <= 1'b0;
		else if (lnk_wfault)
			fault_r <= ~fault_r;
	end

	assign x.req_tgl = req_r;
	assign x.fault_tgl = fault_r;
	assign x.op = op_r;
	assign x.wdata = wd_r;
endmodule
`default_nettype wire

// ==== rtl/dpcs_top.sv ====
/*
 debug port control/status register with sticky flags and abort clears.
 link accesses arrive on link_clk and are carried out on mclk; access port
 events are single mclk pulses; power acks come from another domain.
*/
`timescale 1ns/1ps
`default_nettype none
module dpcs_top #(
	parameter bit SERIAL_WIRE = 1'b1
) (
	// clocks and reset
	input wire logic mclk,
	input wire logic resetn,
	input wire logic link_clk,
	// link-side register access
	input wire logic lnk_rd_csr,
	input wire logic lnk_wr_csr,
	input wire logic lnk_wr_abort,
	input wire logic [dpcs_pkg::CSR_W-1:0] lnk_wdata,
	input wire logic lnk_wfault,
	output logic lnk_busy,
	output logic lnk_rvalid,
	output logic [dpcs_pkg::CSR_W-1:0] lnk_rdata,
	// access port events
	input wire logic ap_resp_err,
	input wire logic ap_read_done,
	input wire logic ap_read_ok,
	input wire logic ap_cmp_match,
	input wire logic ap_overrun,
	input wire logic ap_wr_dropped,
	// power and reset handshake
	input wire logic system_power_on_ack,
	input wire logic debug_power_on_ack,
	input wire logic debug_reset_ack,
	output logic system_power_on_req,
	output logic debug_power_on_req,
	output logic debug_reset_req,
	// controls to the access port
	output logic [dpcs_pkg::CNT_W-1:0] transaction_count,
	output logic [dpcs_pkg::MASK_W-1:0] compare_byte_mask,
	output logic [dpcs_pkg::MODE_W-1:0] transfer_mode_select,
	output logic overrun_detect_enable
);
	import dpcs_pkg::*;
	dpcs_xfer_if x ();
	logic lnk_rst_n;
	logic [ACK_W-1:0] ack_s;
	logic [1:0] tgl_s;
	logic req_seen_r;
	logic fault_seen_r;
	logic ack_tgl_r;
	logic [CSR_W-1:0] rdata_r;
	logic [CSR_W-1:0] csr_word;
	logic op_go;
	logic csr_wr;
	logic abt_wr;
	logic wf_evt;
	logic wf_set, wf_clr, wf_r;
	logic rdok_r;
	logic err_clr, err_r;
	logic cmp_set, cmp_clr, cmp_r;
	logic orun_set, orun_clr, orun_r;

	// link reset follows resetn; link_clk must run while resetn is low
	dpcs_sync #(.W(1)) u_lrst_sync (
		.clk(link_clk),
		.rst_n(1'b1),
		.d(resetn),
		.q(lnk_rst_n)
	);

	dpcs_link u_link (
		.link_clk(link_clk),
		.lnk_rst_n(lnk_rst_n),
		.lnk_rd_csr(lnk_rd_csr),
		.lnk_wr_csr(lnk_wr_csr),
		.lnk_wr_abort(lnk_wr_abort),
		.lnk_wdata(lnk_wdata),
		.lnk_wfault(lnk_wfault),
		.lnk_busy(lnk_busy),
		.lnk_rvalid(lnk_rvalid),
		.lnk_rdata(lnk_rdata),
		.x(x.link)
	);

	// acks come from the power controller's domain
	dpcs_sync #(.W(ACK_W)) u_ack_sync (
		.clk(mclk),
		.rst_n(resetn),
		.d({system_power_on_ack, debug_power_on_ack, debug_reset_ack}),
		.q(ack_s)
	);

	// request and fault toggles from the link domain
	dpcs_sync #(.W(2)) u_tgl_sync (
		.clk(mclk),
		.rst_n(resetn),
		.d({x.req_tgl, x.fault_tgl}),
		.q(tgl_s)
	);

	// decode: op and wdata are held by the link side while the toggle is unanswered
	assign op_go = tgl_s[1] != req_seen_r;
	assign csr_wr = op_go && (x.op == DPCS_OP_WR_CSR);
	assign abt_wr = op_go && (x.op == DPCS_OP_WR_ABORT) && SERIAL_WIRE;
	assign wf_evt = tgl_s[0] != fault_seen_r;

	// handshake: answer each request once, snapshot the word before any write
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			req_seen_r <= 1'b0;
			fault_seen_r <= 1'b0;
			ack_tgl_r <= 1'b0;
			rdata_r <= '0;
		end
		else
		begin
			req_seen_r <= tgl_s[1];
			fault_seen_r <= tgl_s[0];
			if (op_go)
			begin
				ack_tgl_r <= ~ack_tgl_r;
				rdata_r <= csr_word;
			end
		end
	end
	assign x.ack_tgl = ack_tgl_r;
	assign x.rdata = rdata_r;

	// power and debug reset requests
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			system_power_on_req <= 1'b0;
			debug_power_on_req <= 1'b0;
			debug_reset_req <= 1'b0;
		end
		else if (csr_wr)
		begin
			system_power_on_req <= x.wdata[SYS_REQ_B];
			debug_power_on_req <= x.wdata[DBG_REQ_B];
			debug_reset_req <= x.wdata[RST_REQ_B];
		end
	end

	// plain read-write controls; reset to zero for a known start
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			transaction_count <= '0;
			compare_byte_mask <= '0;
			transfer_mode_select <= '0;
			overrun_detect_enable <= 1'b0;
		end
		else if (csr_wr)
		begin
			transaction_count <= x.wdata[CNT_HI_B:CNT_LO_B];
			compare_byte_mask <= x.wdata[MASK_HI_B:MASK_LO_B];
			transfer_mode_select <= x.wdata[MODE_HI_B:MODE_LO_B];
			overrun_detect_enable <= x.wdata[ORUN_EN_B];
		end
	end

	// set and clear terms; sets win because the flag update below ORs them in after the clear
	assign wf_set = SERIAL_WIRE && (wf_evt || ap_wr_dropped);
	assign wf_clr = abt_wr && x.wdata[AB_WF_B];
	assign err_clr = SERIAL_WIRE ? (abt_wr && x.wdata[AB_ERR_B]) :
		(csr_wr && x.wdata[STKERR_B]);
	assign cmp_set = SERIAL_WIRE && ap_cmp_match;
	assign cmp_clr = abt_wr && x.wdata[AB_CMP_B];
	assign orun_set = SERIAL_WIRE && overrun_detect_enable && ap_overrun;
	assign orun_clr = abt_wr && x.wdata[AB_ORUN_B];

	// sticky flags: a zero write bit clears nothing, a set beats a clear
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			wf_r <= 1'b0;
			err_r <= 1'b0;
			cmp_r <= 1'b0;
			orun_r <= 1'b0;
		end
		else
		begin
			wf_r <= wf_set | (wf_r & ~wf_clr);
			err_r <= ap_resp_err | (err_r & ~err_clr);
			cmp_r <= cmp_set | (cmp_r & ~cmp_clr);
			orun_r <= orun_set | (orun_r & ~orun_clr);
		end
	end

	// last read response, scan-chain keeps it at zero
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			rdok_r <= 1'b0;
		else if (ap_read_done)
			rdok_r <= SERIAL_WIRE && ap_read_ok;
	end

	// read view; reserved and absent bits read zero
	always_comb
	begin
		csr_word = '0;
		csr_word[SYS_ACK_B] = ack_s[2];
		csr_word[SYS_REQ_B] = system_power_on_req;
		csr_word[DBG_ACK_B] = ack_s[1];
		csr_word[DBG_REQ_B] = debug_power_on_req;
		csr_word[RST_ACK_B] = ack_s[0];
		csr_word[RST_REQ_B] = debug_reset_req;
		csr_word[CNT_HI_B:CNT_LO_B] = transaction_count;
		csr_word[MASK_HI_B:MASK_LO_B] = compare_byte_mask;
		csr_word[WFAULT_B] = wf_r;
		csr_word[RDOK_B] = rdok_r;
		csr_word[STKERR_B] = err_r;
		csr_word[STKCMP_B] = cmp_r;
		csr_word[MODE_HI_B:MODE_LO_B] = transfer_mode_select;
		csr_word[ORUN_B] = orun_r;
		csr_word[ORUN_EN_B] = overrun_detect_enable;
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	a_ack_reflect: assert property (
		$past(resetn, 2) |-> {csr_word[SYS_ACK_B], csr_word[DBG_ACK_B], csr_word[RST_ACK_B]}
		== $past({system_power_on_ack, debug_power_on_ack, debug_reset_ack}, 2))
		else $error("ack bits do not follow the acks");
	a_req_store: assert property (
		csr_wr |=> {system_power_on_req, debug_power_on_req, debug_reset_req}
		== $past({x.wdata[SYS_REQ_B], x.wdata[DBG_REQ_B], x.wdata[RST_REQ_B]}))
		else $error("request bits not written");
	a_field_store: assert property (
		csr_wr |=> transaction_count == $past(x.wdata[CNT_HI_B:CNT_LO_B])
		&& compare_byte_mask == $past(x.wdata[MASK_HI_B:MASK_LO_B])
		&& transfer_mode_select == $past(x.wdata[MODE_HI_B:MODE_LO_B]))
		else $error("count, mask or mode not written");
	a_wfault_set: assert property (
		(SERIAL_WIRE && ap_wr_dropped) |=> csr_word[WFAULT_B] [*2] or (csr_word[WFAULT_B] ##1 1'b1))
		else $error("dropped write did not set fault flag");
	a_wfault_hold: assert property (
		(wf_r && !(abt_wr && x.wdata[AB_WF_B])) |=> wf_r)
		else $error("write fault flag cleared without abort");
	a_rdok_track: assert property (
		ap_read_done |=> rdok_r == (SERIAL_WIRE && $past(ap_read_ok)))
		else $error("read ok flag wrong");
	a_err_set: assert property (
		ap_resp_err |=> err_r ##1 (err_r || $past(err_clr)))
		else $error("access error not sticky");
	a_cmp_set: assert property (
		(SERIAL_WIRE && ap_cmp_match) |=> cmp_r)
		else $error("compare match lost");
	a_orun_gate: assert property (
		(!overrun_detect_enable && !orun_r) |=> !orun_r)
		else $error("overrun set while detection off");
	a_orun_clr: assert property (
		(abt_wr && x.wdata[AB_ORUN_B] && !orun_set) |=> !orun_r)
		else $error("abort did not clear overrun");
	a_reserved_zero: assert property (
		csr_word[RST_REQ_B-1:CNT_HI_B+1] == 2'h0 && (SERIAL_WIRE ||
		{csr_word[WFAULT_B], csr_word[RDOK_B], csr_word[STKCMP_B], csr_word[ORUN_B]} == 4'h0))
		else $error("reserved bits read nonzero");
	a_scan_clear: assert property (
		(!SERIAL_WIRE && csr_wr && x.wdata[STKERR_B] && !ap_resp_err) |=> !err_r)
		else $error("scan-chain write-1 did not clear error");
	a_zero_keeps: assert property (
		(abt_wr && !x.wdata[AB_ERR_B] && err_r) |=> err_r)
		else $error("zero abort bit cleared error");

	// clears: a one in the clear bit empties the flag unless a set lands in the same cycle
	a_wfault_clear: assert property (
		(wf_clr && !wf_set)
		|=> !wf_r)
		else $error("abort did not clear write fault");
	a_err_clear: assert property (
		(err_clr && !ap_resp_err)
		|=> !err_r)
		else $error("clear did not empty access error");
	a_cmp_clear: assert property (
		(cmp_clr && !cmp_set)
		|=> !cmp_r)
		else $error("abort did not clear compare match");
	a_set_wins: assert property (
		(ap_resp_err && err_clr)
		|=> err_r)
		else $error("clear beat a same-cycle error");
	// sets and holds: flags move only on their own events
	a_wfault_link: assert property (
		(SERIAL_WIRE && wf_evt)
		|=> wf_r)
		else $error("link fault did not set write fault");
	a_err_hold: assert property (
		(err_r && !err_clr)
		|=> err_r)
		else $error("access error dropped without a clear");
	a_orun_set: assert property (
		(SERIAL_WIRE && overrun_detect_enable && ap_overrun)
		|=> orun_r)
		else $error("overrun lost while detection on");
	a_rdok_hold: assert property (
		!ap_read_done
		|=> $stable(rdok_r))
		else $error("read ok flag moved without a read");
	// register fields: the enable follows the written word
	a_enable_store: assert property (
		csr_wr
		|=> overrun_detect_enable == $past(x.wdata[ORUN_EN_B]))
		else $error("overrun enable not written");
	// scan-chain: the serial-wire-only flags never leave zero
	a_scan_quiet: assert property (
		!SERIAL_WIRE
		|-> !(wf_r || rdok_r || cmp_r || orun_r))
		else $error("serial-wire flag set on scan-chain");

	c_read_op: cover property (op_go && x.op == DPCS_OP_RD_CSR);
	c_abort_clear: cover property (err_r ##1 (abt_wr && x.wdata[AB_ERR_B]) ##1 !err_r);
	c_set_and_clear: cover property (ap_resp_err && err_clr);
	c_overrun: cover property (orun_set);
	// scan-chain clear through the register itself
	c_scan_clear: cover property (!SERIAL_WIRE && err_r && csr_wr && x.wdata[STKERR_B]);
endmodule
`default_nettype wire

// ==== test/dpcs_dbg_model.sv ====
/*
 debugger model: makes register reads, writes and abort writes on the
 decoded link strobes. assumes link_clk runs freely, as the device needs.
*/
`timescale 1ns/1ps
`default_nettype none
module dpcs_dbg_model (
	// link clock
	input wire logic link_clk,
	// strobes to the device
	output logic lnk_rd_csr,
	output logic lnk_wr_csr,
	output logic lnk_wr_abort,
	output logic [31:0] lnk_wdata,
	output logic lnk_wfault,
	// answers
	input wire logic lnk_busy,
	input wire logic lnk_rvalid,
	input wire logic [31:0] lnk_rdata
);
	int slow = 0; // each access first waits slow + 1 link cycles
	initial
	begin
		{lnk_rd_csr, lnk_wr_csr, lnk_wr_abort, lnk_wfault} = 4'h0;
		lnk_wdata = 32'h0;
	end
	// one access, kind 0 read, 1 write, 2 abort; dup holds the strobe a
	// second cycle with other data, which the device must drop
	task automatic xfer(input int kind, input logic [31:0] d, input bit dup,
		output logic [31:0] q, output bit ok);
		ok = 1'b0;
		q = 32'h0;
		repeat (slow + 1) @(posedge link_clk);
		#1;
		lnk_rd_csr = (kind == 0);
		lnk_wr_csr = (kind == 1);
		lnk_wr_abort = (kind == 2);
		lnk_wdata = d;
		@(posedge link_clk);
		#1;
		if (dup)
		begin
			lnk_wdata = ~d;
			@(posedge link_clk);
			#1;
		end
		{lnk_rd_csr, lnk_wr_csr, lnk_wr_abort} = 3'h0;
		lnk_wdata = ~lnk_wdata; // a released bus never keeps the last word
		for (int n = 0; n < 100 && !ok; n++)
		begin
			@(posedge link_clk);
			#1;
			ok = (lnk_busy === 1'b0);
			q = (lnk_rvalid === 1'b1) ? lnk_rdata : 'x;
		end
	endtask
	// one bad write data phase
	task automatic fault();
		@(posedge link_clk);
		#1;
		lnk_wfault = 1'b1;
		@(posedge link_clk);
		#1;
		lnk_wfault = 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== test/debug_port_ctrl_status_test.sv ====
/*
 self-checking bench: the debugger model makes link accesses, the bench
 pulses access port events and compares each result with a model.
 runs the serial-wire and scan-chain variants side by side on one stimulus.
*/
`timescale 1ns/1ps
`default_nettype none
module debug_port_ctrl_status_test;
	import dpcs_pkg::*;
	localparam logic [31:0] WMASK = 32'h54FF_FF0D; // writable bits
	logic mclk = 1'b0;
	logic link_clk = 1'b0;
	logic resetn = 1'b0;
	logic [5:0] apv = 6'h00; // err, rdone, rok, cmp, orun, drop
	logic [2:0] ak = 3'h0; // sys, dbg, rst acks
	logic rd_s, wr_s, ab_s, wf_s, busy, rv, oen, sreq, dreq, rreq;
	logic [31:0] wd;
	logic [31:0] rdw;
	logic [CNT_W-1:0] cnt;
	logic [MASK_W-1:0] msk;
	logic [MODE_W-1:0] mode;
	// scan-chain instance results
	logic sreq_j, dreq_j, rreq_j, oen_j;
	logic [31:0] rdw_j;
	logic [CNT_W-1:0] cnt_j;
	logic [MASK_W-1:0] msk_j;
	logic [MODE_W-1:0] mode_j;
	logic [5:0] tbl [8] = '{6'h20, 6'h18, 6'h10, 6'h08, 6'h18, 6'h04, 6'h02, 6'h01};
	// model state
	logic [31:0] rw = 32'h0;
	logic wf = 1'b0;
	logic rok = 1'b0;
	logic se = 1'b0;
	logic se_j = 1'b0; // scan-chain sticky error
	logic sc = 1'b0;
	logic so = 1'b0;
	int n_errors = 0;
	int total_checks = 0;
	always #12.5 mclk = ~mclk;
	// link clock offset so its edges never line up with mclk
	initial
	begin
		#1.7;
		forever #3 link_clk = ~link_clk;
	end
	dpcs_top DUT (.mclk(mclk), .resetn(resetn), .link_clk(link_clk),
		.lnk_rd_csr(rd_s), .lnk_wr_csr(wr_s), .lnk_wr_abort(ab_s), .lnk_wdata(wd),
		.lnk_wfault(wf_s), .lnk_busy(busy), .lnk_rvalid(rv), .lnk_rdata(rdw),
		.ap_resp_err(apv[5]), .ap_read_done(apv[4]), .ap_read_ok(apv[3]),
		.ap_cmp_match(apv[2]), .ap_overrun(apv[1]), .ap_wr_dropped(apv[0]),
		.system_power_on_ack(ak[2]), .debug_power_on_ack(ak[1]),
		.debug_reset_ack(ak[0]), .system_power_on_req(sreq),
		.debug_power_on_req(dreq), .debug_reset_req(rreq),
		.transaction_count(cnt), .compare_byte_mask(msk),
		.transfer_mode_select(mode), .overrun_detect_enable(oen));
	// scan-chain variant on the same strobes; its handshake timing matches DUT
	dpcs_top #(.SERIAL_WIRE(1'b0)) DUT_SCAN (.mclk(mclk), .resetn(resetn),
		.link_clk(link_clk),
		.lnk_rd_csr(rd_s), .lnk_wr_csr(wr_s), .lnk_wr_abort(ab_s), .lnk_wdata(wd),
		.lnk_wfault(wf_s), .lnk_busy(), .lnk_rvalid(), .lnk_rdata(rdw_j),
		.ap_resp_err(apv[5]), .ap_read_done(apv[4]), .ap_read_ok(apv[3]),
		.ap_cmp_match(apv[2]), .ap_overrun(apv[1]), .ap_wr_dropped(apv[0]),
		.system_power_on_ack(ak[2]), .debug_power_on_ack(ak[1]),
		.debug_reset_ack(ak[0]), .system_power_on_req(sreq_j),
		.debug_power_on_req(dreq_j), .debug_reset_req(rreq_j),
		.transaction_count(cnt_j), .compare_byte_mask(msk_j),
		.transfer_mode_select(mode_j), .overrun_detect_enable(oen_j));
	dpcs_dbg_model dbg (.link_clk(link_clk), .lnk_rd_csr(rd_s), .lnk_wr_csr(wr_s),
		.lnk_wr_abort(ab_s), .lnk_wdata(wd), .lnk_wfault(wf_s), .lnk_busy(busy),
		.lnk_rvalid(rv), .lnk_rdata(rdw));
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected word at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_ctl(input logic [21:0] got, input logic [21:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected controls at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] exp_word();
		return rw | {ak[2], 1'b0, ak[1], 1'b0, ak[0], 27'h0}
			| {24'h0, wf, rok, se, sc, 2'h0, so, 1'b0};
	endfunction
	// scan-chain view: only the sticky error survives of the flags
	function automatic logic [31:0] exp_scan();
		return rw | {ak[2], 1'b0, ak[1], 1'b0, ak[0], 27'h0} | {26'h0, se_j, 5'h0};
	endfunction
	// a hung access counts as a mismatch and ends the run
	task automatic acc(input int kind, input logic [31:0] d, input bit dup,
		output logic [31:0] q);
		bit ok;
		dbg.xfer(kind, d, dup, q, ok);
		if (!ok)
		begin
			n_errors++;
			$display("unexpected hang at %0t: got %h exp %h", $time, 1'b0, 1'b1);
			tally_and_finish();
		end
	endtask
	task automatic rd_check();
		logic [31:0] q;
		acc(0, 32'h0, 1'b0, q);
		chk_word(q, exp_word());
		chk_word(rdw_j, exp_scan());
	endtask
	task automatic wr(input logic [31:0] d, input bit dup);
		logic [31:0] q;
		acc(1, d, dup, q);
		rw = d & WMASK;
		se_j &= ~d[5]; // scan-chain clears on write-1, serial-wire ignores it
		chk_ctl({cnt_j, msk_j, mode_j, oen_j, sreq_j, dreq_j, rreq_j},
			{rw[23:8], rw[3:2], rw[0], rw[30], rw[28], rw[26]});
		chk_ctl({cnt, msk, mode, oen, sreq, dreq, rreq},
			{rw[23:8], rw[3:2], rw[0], rw[30], rw[28], rw[26]});
	endtask
	task automatic ab(input logic [31:0] d);
		logic [31:0] q;
		acc(2, d, 1'b0, q);
		{so, wf, se, sc} = {so, wf, se, sc} & ~d[4:1];
	endtask
	// one mclk pulse of the access port events, then the model follows
	task automatic ev(input logic [5:0] m);
		@(posedge mclk);
		#2;
		apv = m;
		@(posedge mclk);
		#2;
		apv = 6'h00;
		se |= m[5];
		se_j |= m[5];
		rok = m[4] ? m[3] : rok;
		sc |= m[2];
		so |= m[1] & rw[0];
		wf |= m[0];
	endtask
	initial
	begin
		logic [31:0] d;
		d = $urandom(1);
		repeat (16) @(posedge mclk);
		#2;
		resetn = 1'b1;
		repeat (4) @(posedge mclk);
		rd_check();
		for (int i = 0; i < 8; i++)
		begin
			d = $urandom();
			@(posedge mclk);
			#2;
			ak = d[31:29] ^ d[2:0];
			wr(d, 1'b0);
			rd_check();
		end
		wr(32'h0000_3000, 1'b1);
		rd_check();
		wr(32'h0, 1'b0);
		ev(6'h02);
		rd_check();
		wr(32'h1, 1'b0);
		foreach (tbl[i])
		begin
			ev(tbl[i]);
			rd_check();
		end
		ab(32'h0000_0008);
		rd_check();
		dbg.fault();
		repeat (8) @(posedge mclk);
		wf = 1'b1;
		rd_check();
		wr(32'h0000_00F3, 1'b0);
		rd_check();
		ab(32'hFFFF_FFE1);
		rd_check();
		for (int i = 1; i < 5; i++)
		begin
			dbg.slow = i;
			ab(32'h1 << i);
			rd_check();
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
